// ===== core/rvm_vector_map.sv
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - erase success unsecures and reprograms security byte
// - all resets use fixed vector, never masked
// - por, lvr, pin reset unconditional; clkmon needs osc
// - watchdog reset enabled by nonzero rate field
// - higher vector offset wins arbitration
// - vector equals base register plus offset
// - page1 opcode trap vectors base plus 0x1f8
// - page2 opcode trap vectors base plus 0x1f4
// - software interrupt vectors base plus 0x1f0
// - system call vectors base plus 0x1ec
// - timer channels and overflow: masked, wake wait
// - accumulator overflow: masked, enabled, wakes wait only
// - accumulator edge: masked, enabled, wakes wait only
module rvm_vector_map
    import rvm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register bus
    input wire rvm_pkg::rvm_wb_req_t wb_req,
    output logic wb_ack,
    output logic [31:0] wb_rdata,
    // reset sources, pins are asynchronous
    input wire logic por_pin,
    input wire logic lvr_pin,
    input wire logic ext_reset_n_pin,
    input wire logic nonmaskable_ext_request_n_pin,
    input wire logic clk_mon_fail,
    input wire logic wdog_timeout,
    // flash
    input wire logic [1:0] sec_bits,
    input wire logic erase_done,
    input wire logic erase_ok,
    output logic sec_prog,
    output logic [1:0] sec_prog_value,
    // peripherals and cpu
    input wire rvm_pkg::rvm_periph_evt_t evt,
    input wire rvm_pkg::rvm_cpu_t cpu,
    // vector outputs
    output logic reset_req,
    output logic [23:0] reset_vec,
    output logic irq_req,
    output logic [23:0] irq_vec,
    output logic wake_wait,
    output logic wake_stop
);
    import rvm_pkg::*;

    rvm_state_t st_q, st_d;
    logic [RVM_NREQ-1:0] req;
    logic [31:0] wmask;
    logic wr_go;
    logic nonmaskable_ext_request_act;

    // arbitration requests, index 0 holds the highest offset
    always_comb begin
        nonmaskable_ext_request_act = ~st_q.flt[RVM_PIN_NONMASKABLE_EXT_REQUEST];
        req = '0;
        req[3:0] = st_q.traps;
        req[RVM_IDX_NONMASKABLE_EXT_REQUEST] = nonmaskable_ext_request_act & ~cpu.ccr_x_mask;
        for (int i = 0; i < 8; i++) begin
            req[5 + i] = st_q.flags[i] & st_q.tim_ie[i] & ~cpu.ccr_i_mask;
        end
        req[13] = st_q.flags[8] & st_q.timer_overflow_ie & ~cpu.ccr_i_mask;
        req[14] = st_q.flags[9] & st_q.pulse_acc_overflow_ie & ~cpu.ccr_i_mask;
        req[15] = st_q.flags[10] & st_q.pulse_acc_edge_ie & ~cpu.ccr_i_mask;
    end

    assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}},
                    {8{wb_req.sel[0]}}};
    // write lands on the edge where the master sees ack
    assign wr_go = wb_req.cyc & wb_req.stb & wb_req.we & st_q.ack;

    // next state
    always_comb begin
        logic [31:0] wv;
        logic [31:0] rd;
        logic found;
        wv = wb_req.dat & wmask;
        rd = '0;
        found = 1'b0;
        st_d = st_q;
        // three-stage pin synchronisers, change accepted when stages 2 and 3 agree
        st_d.sh[RVM_PIN_POR] = {st_q.sh[RVM_PIN_POR][1:0], por_pin};
        st_d.sh[RVM_PIN_LVR] = {st_q.sh[RVM_PIN_LVR][1:0], lvr_pin};
        st_d.sh[RVM_PIN_EXT] = {st_q.sh[RVM_PIN_EXT][1:0], ~ext_reset_n_pin};
        st_d.sh[RVM_PIN_NONMASKABLE_EXT_REQUEST] = {st_q.sh[RVM_PIN_NONMASKABLE_EXT_REQUEST][1:0], nonmaskable_ext_request_n_pin};
        for (int p = 0; p < 4; p++) begin
            if (st_q.sh[p][1] == st_q.sh[p][2]) begin
                st_d.flt[p] = st_q.sh[p][2];
            end
        end
        // reset request; no mask bit takes part here
        st_d.rst_req = st_q.flt[RVM_PIN_POR] | st_q.flt[RVM_PIN_LVR]
                     | st_q.flt[RVM_PIN_EXT]
                     | (clk_mon_fail & st_q.osc_en)
                     | (wdog_timeout & (st_q.wd_rate != 3'h0));
        // bus slave, one wait state, unmapped reads as zero
        st_d.ack = wb_req.cyc & wb_req.stb & ~st_q.ack;
        unique case (wb_req.adr & 8'hfc)
            RVM_REG_VBR: rd = {8'h00, st_q.vbr};
            RVM_REG_WDOG: rd = {29'h0, st_q.wd_rate};
            RVM_REG_OSC: rd = 32'(st_q.osc_en) << RVM_OSC_EN_BIT;
            RVM_REG_TIE: rd = {24'h0, st_q.tim_ie};
            RVM_REG_TSC2: rd = 32'(st_q.timer_overflow_ie) << RVM_TOI_BIT;
            RVM_REG_PACTL: rd = {30'h0, st_q.pulse_acc_overflow_ie, st_q.pulse_acc_edge_ie};
            RVM_REG_FLAGS: rd = {21'h0, st_q.flags};
            RVM_REG_RSTAT: rd = {23'h0, st_q.secured, 3'h0, st_q.rst_cause};
            RVM_REG_CURVEC: rd = {st_q.irq_req, 7'h00, st_q.irq_vec};
            default: rd = '0;
        endcase
        st_d.rdata = st_d.ack ? rd : st_q.rdata;
        if (wr_go) begin
            unique case (wb_req.adr & 8'hfc)
                RVM_REG_VBR: st_d.vbr = 24'((32'(st_q.vbr) & ~wmask) | wv);
                RVM_REG_WDOG: if (wb_req.sel[0]) st_d.wd_rate = wb_req.dat[2:0];
                RVM_REG_OSC: if (wb_req.sel[0]) st_d.osc_en = wb_req.dat[RVM_OSC_EN_BIT];
                RVM_REG_TIE: if (wb_req.sel[0]) st_d.tim_ie = wb_req.dat[7:0];
                RVM_REG_TSC2: if (wb_req.sel[0]) st_d.timer_overflow_ie = wb_req.dat[RVM_TOI_BIT];
                RVM_REG_PACTL: begin
                    if (wb_req.sel[0]) begin
                        st_d.pulse_acc_overflow_ie = wb_req.dat[RVM_PULSE_ACC_OVERFLOW_IE_BIT];
                        st_d.pulse_acc_edge_ie = wb_req.dat[RVM_PAI_BIT];
                    end
                end
                RVM_REG_FLAGS: st_d.flags = st_q.flags & ~wv[10:0];
                RVM_REG_RSTAT: st_d.rst_cause = st_q.rst_cause & ~wv[4:0];
                default: ;
            endcase
        end
        // source flags: set after clear so a coincident event survives
        st_d.flags = st_d.flags | {evt.pa_edge, evt.pa_ovf, evt.tim_ovf, evt.tim_ch};
        // sticky reset causes, also set-wins
        st_d.rst_cause[RVM_RC_POR] |= st_q.flt[RVM_PIN_POR];
        st_d.rst_cause[RVM_RC_LVR] |= st_q.flt[RVM_PIN_LVR];
        st_d.rst_cause[RVM_RC_EXT] |= st_q.flt[RVM_PIN_EXT];
        st_d.rst_cause[RVM_RC_CLKMON] |= clk_mon_fail & st_q.osc_en;
        st_d.rst_cause[RVM_RC_WDOG] |= wdog_timeout & (st_q.wd_rate != 3'h0);
        // trap pendings drop when the cpu takes their vector
        if (cpu.vec_ack && st_q.irq_req && st_q.irq_src < RVM_IDX_NONMASKABLE_EXT_REQUEST) begin
            st_d.traps[st_q.irq_src[1:0]] = 1'b0;
        end
        st_d.traps = st_d.traps | {cpu.system_call_instr, cpu.software_irq_instr, cpu.trap2, cpu.trap1};
        // fixed priority: first hit is the highest offset
        st_d.irq_req = 1'b0;
        st_d.irq_src = st_q.irq_src;
        for (int i = 0; i < RVM_NREQ; i++) begin
            if (req[i] && !found) begin
                found = 1'b1;
                st_d.irq_req = 1'b1;
                st_d.irq_src = 4'(i);
            end
        end
        st_d.irq_vec = st_q.vbr + {15'h0, rvm_vec_off(st_d.irq_src)};
        // full erase unsecures without software help
        st_d.sec_prog = erase_done & erase_ok;
        if (erase_done && erase_ok) begin
            st_d.secured = 1'b0;
        end
        if (srst) begin
            st_d = '0;
            st_d.vbr = RVM_VBR_RST;
            st_d.flt[RVM_PIN_NONMASKABLE_EXT_REQUEST] = 1'b1;
            st_d.sh[RVM_PIN_NONMASKABLE_EXT_REQUEST] = 3'h7;
            // security strap caught on the clock, srst is synchronous
            st_d.secured = (sec_bits != RVM_SEC_UNSECURED);
        end
    end

    // the single state register
    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    // outputs
    assign wb_ack = st_q.ack;
    assign wb_rdata = st_q.rdata;
    assign reset_req = st_q.rst_req;
    assign reset_vec = RVM_RESET_VEC;
    assign irq_req = st_q.irq_req;
    assign irq_vec = st_q.irq_vec;
    assign sec_prog = st_q.sec_prog;
    assign sec_prog_value = RVM_SEC_UNSECURED;
    // only the external nonmaskable request may end stop; timers never do
    assign wake_stop = nonmaskable_ext_request_act & ~cpu.ccr_x_mask;
    assign wake_wait = |req;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic others_idle;
    assign others_idle = ~st_q.flt[RVM_PIN_POR] & ~st_q.flt[RVM_PIN_LVR]
                       & ~st_q.flt[RVM_PIN_EXT];

    a_erase_unsec: assert property (erase_done && erase_ok |=> !st_q.secured && sec_prog)
        else $error("erase did not unsecure");
    a_reset_vector: assert property (reset_req |-> reset_vec == RVM_RESET_VEC)
        else $error("reset vector not fixed");
    a_por_reset: assert property ($rose(st_q.flt[RVM_PIN_POR]) |=> reset_req)
        else $error("por did not reset");
    a_clkmon_gate: assert property (others_idle && !st_q.osc_en && !wdog_timeout |=> !reset_req)
        else $error("clock monitor reset without osc enable");
    a_wdog_reset: assert property (wdog_timeout && st_q.wd_rate != 3'h0 |=> reset_req)
        else $error("watchdog reset lost");
    a_prio_order: assert property (req[5] && req[6] && req[4:0] == 5'h0 |=> irq_src_is(4'h5))
        else $error("lower offset won");
    a_trap1_vec: assert property (st_q.traps[0] |=> irq_vec == $past(st_q.vbr) + 24'h1f8)
        else $error("page1 trap vector wrong");
    a_trap2_vec: assert property (req[3:0] == 4'h2 |=> irq_vec == $past(st_q.vbr) + 24'h1f4)
        else $error("page2 trap vector wrong");
    a_swi_vec: assert property (req[3:0] == 4'h4 |=> irq_vec == $past(st_q.vbr) + 24'h1f0)
        else $error("swi vector wrong");
    a_sys_vec: assert property (req[3:0] == 4'h8 |=> irq_vec == $past(st_q.vbr) + 24'h1ec)
        else $error("system call vector wrong");
    a_imask_block: assert property (cpu.ccr_i_mask && req[4:0] == 5'h0 |-> !wake_wait)
        else $error("masked request got through");
    a_flag_hold: assert property (st_q.flags[9] && !wr_go |=> st_q.flags[9])
        else $error("flag lost without clear");
    a_edge_gate: assert property (!st_q.pulse_acc_edge_ie |-> !req[15])
        else $error("edge request without enable");
    a_nonmaskable_ext_request_stop: assert property (wake_stop |=> irq_req)
        else $error("stop wake without external request");
    a_x_block: assert property (cpu.ccr_x_mask |-> !wake_stop)
        else $error("x mask did not block");
    a_nonmaskable_ext_request_no_i: assert property (nonmaskable_ext_request_act && cpu.ccr_i_mask
        && !cpu.ccr_x_mask |-> wake_wait)
        else $error("i mask blocked external request");

    // selected source against base plus its offset; the base is one edge old
    function automatic logic vec_is(input logic [3:0] s, input logic [23:0] v);
        return !st_q.irq_req || st_q.irq_src != s || st_q.irq_vec == v;
    endfunction : vec_is

    a_trap1_sel: assert property (vec_is(4'h0, $past(st_q.vbr) + 24'h1f8))
        else $error("page1 trap selection vector wrong");
    a_trap2_sel: assert property (vec_is(4'h1, $past(st_q.vbr) + 24'h1f4))
        else $error("page2 trap selection vector wrong");
    a_swi_sel: assert property (vec_is(4'h2, $past(st_q.vbr) + 24'h1f0))
        else $error("swi selection vector wrong");
    a_sys_sel: assert property (vec_is(4'h3, $past(st_q.vbr) + 24'h1ec))
        else $error("system call selection vector wrong");
    a_nonmaskable_ext_request_vec: assert property (vec_is(RVM_IDX_NONMASKABLE_EXT_REQUEST, $past(st_q.vbr) + 24'h1d8))
        else $error("external request vector wrong");
    a_ch0_vec: assert property (vec_is(RVM_IDX_TIM0, $past(st_q.vbr) + 24'h1cc))
        else $error("channel 0 vector wrong");
    a_ch7_vec: assert property (vec_is(4'hc, $past(st_q.vbr) + 24'h1b0))
        else $error("channel 7 vector wrong");
    a_tovf_vec: assert property (vec_is(4'hd, $past(st_q.vbr) + 24'h1ac))
        else $error("timer overflow vector wrong");
    a_paovf_vec: assert property (vec_is(4'he, $past(st_q.vbr) + 24'h1a8))
        else $error("accumulator overflow vector wrong");
    a_paedge_vec: assert property (vec_is(4'hf, $past(st_q.vbr) + 24'h1a4))
        else $error("accumulator edge vector wrong");

    // reset sources and their sticky causes
    a_lvr_reset: assert property ($rose(st_q.flt[RVM_PIN_LVR]) |=> reset_req)
        else $error("low voltage did not reset");
    a_ext_reset: assert property ($rose(st_q.flt[RVM_PIN_EXT]) |=> reset_req)
        else $error("pin did not reset");
    a_clkmon_reset: assert property (clk_mon_fail && st_q.osc_en |=> reset_req)
        else $error("clock monitor reset lost");
    a_wdog_gate: assert property (st_q.wd_rate == 3'h0 && others_idle
        && !(clk_mon_fail && st_q.osc_en) |=> !reset_req)
        else $error("watchdog reset without rate");
    a_por_cause: assert property (st_q.flt[RVM_PIN_POR] |=> st_q.rst_cause[RVM_RC_POR])
        else $error("power on cause lost");
    a_wdog_cause: assert property (wdog_timeout && st_q.wd_rate != 3'h0
        |=> st_q.rst_cause[RVM_RC_WDOG])
        else $error("watchdog cause lost");

    // masks, enables and held flags
    a_imask_all: assert property (cpu.ccr_i_mask |-> req[15:5] == 11'h000)
        else $error("maskable request while i set");
    a_enable_gate: assert property (!st_q.tim_ie[0] |-> !req[5])
        else $error("channel request without enable");
    a_flag_set: assert property (evt.pa_ovf |=> st_q.flags[9])
        else $error("overflow flag not set");

    // trap pendings
    a_trap_keep: assert property (st_q.traps[1] && !cpu.vec_ack |=> st_q.traps[1])
        else $error("page2 trap dropped untaken");
    a_trap_set: assert property (cpu.software_irq_instr |=> st_q.traps[2])
        else $error("swi not pending");

    // security
    a_unsec_hold: assert property (!st_q.secured |=> !st_q.secured)
        else $error("device secured again");
    a_sec_value: assert property (sec_prog |-> sec_prog_value == RVM_SEC_UNSECURED)
        else $error("security byte value wrong");

    function automatic logic irq_src_is(input logic [3:0] s);
        return st_q.irq_req && st_q.irq_src == s;
    endfunction : irq_src_is

    c_trap_taken: cover property (st_q.traps[0] ##1 cpu.vec_ack);
    c_timer_irq: cover property (req[5] ##1 irq_req);
    c_wdog_rst: cover property (wdog_timeout && st_q.wd_rate != 3'h0 ##1 reset_req);
    c_erase: cover property (erase_done && erase_ok && st_q.secured);
    c_nonmaskable_ext_request_wake: cover property (wake_stop ##1 irq_req);

endmodule : rvm_vector_map

// ===== core/rvm_pkg.sv
package rvm_pkg;

    // vector addresses and offsets
    localparam logic [23:0] RVM_RESET_VEC = 24'h0ffffc;
    localparam logic [23:0] RVM_VBR_RST = 24'hfffe00;
    localparam logic [8:0] RVM_OFF_TRAP1 = 9'h1f8;
    localparam logic [8:0] RVM_OFF_TRAP2 = 9'h1f4;
    localparam logic [8:0] RVM_OFF_SWI = 9'h1f0;
    localparam logic [8:0] RVM_OFF_SYS = 9'h1ec;
    localparam logic [8:0] RVM_OFF_NONMASKABLE_EXT_REQUEST = 9'h1d8;
    localparam logic [8:0] RVM_OFF_TIM_CH0 = 9'h1cc;
    localparam logic [8:0] RVM_OFF_STEP = 9'h004;

    // request index order, highest offset first
    localparam int RVM_NREQ = 16;
    localparam logic [3:0] RVM_IDX_NONMASKABLE_EXT_REQUEST = 4'h4;
    localparam logic [3:0] RVM_IDX_TIM0 = 4'h5;

    // register word offsets (byte addresses)
    localparam logic [7:0] RVM_REG_VBR = 8'h00;
    localparam logic [7:0] RVM_REG_WDOG = 8'h04;
    localparam logic [7:0] RVM_REG_OSC = 8'h08;
    localparam logic [7:0] RVM_REG_TIE = 8'h0c;
    localparam logic [7:0] RVM_REG_TSC2 = 8'h10;
    localparam logic [7:0] RVM_REG_PACTL = 8'h14;
    localparam logic [7:0] RVM_REG_FLAGS = 8'h18;
    localparam logic [7:0] RVM_REG_RSTAT = 8'h1c;
    localparam logic [7:0] RVM_REG_CURVEC = 8'h20;

    // field positions
    localparam int RVM_OSC_EN_BIT = 7;
    localparam int RVM_TOI_BIT = 7;
    localparam int RVM_PULSE_ACC_OVERFLOW_IE_BIT = 1;
    localparam int RVM_PAI_BIT = 0;
    localparam int RVM_SECURED_BIT = 8;
    localparam int RVM_CURVEC_REQ_BIT = 31;

    // pin index into synchronisers
    localparam int RVM_PIN_POR = 0;
    localparam int RVM_PIN_LVR = 1;
    localparam int RVM_PIN_EXT = 2;
    localparam int RVM_PIN_NONMASKABLE_EXT_REQUEST = 3;

    // reset cause bits
    localparam int RVM_RC_POR = 0;
    localparam int RVM_RC_LVR = 1;
    localparam int RVM_RC_EXT = 2;
    localparam int RVM_RC_CLKMON = 3;
    localparam int RVM_RC_WDOG = 4;

    // security byte
    localparam logic [1:0] RVM_SEC_UNSECURED = 2'h2;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rvm_wb_req_t;

    typedef struct packed {
        logic [7:0] tim_ch;
        logic tim_ovf;
        logic pa_ovf;
        logic pa_edge;
    } rvm_periph_evt_t;

    typedef struct packed {
        logic trap1;
        logic trap2;
        logic software_irq_instr;
        logic system_call_instr;
        logic vec_ack;
        logic ccr_i_mask;
        logic ccr_x_mask;
    } rvm_cpu_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [23:0] vbr;
        logic [2:0] wd_rate;
        logic osc_en;
        logic [7:0] tim_ie;
        logic timer_overflow_ie;
        logic pulse_acc_overflow_ie;
        logic pulse_acc_edge_ie;
        logic [10:0] flags;
        logic [3:0] traps;
        logic [3:0][2:0] sh;
        logic [3:0] flt;
        logic rst_req;
        logic [4:0] rst_cause;
        logic secured;
        logic sec_prog;
        logic irq_req;
        logic [3:0] irq_src;
        logic [23:0] irq_vec;
    } rvm_state_t;

    // fixed offset of each request index
    function automatic logic [8:0] rvm_vec_off(input logic [3:0] idx);
        logic [8:0] off;
        off = RVM_OFF_TRAP1 - 9'({idx[1:0], 2'b00});
        if (idx == RVM_IDX_NONMASKABLE_EXT_REQUEST) begin
            off = RVM_OFF_NONMASKABLE_EXT_REQUEST;
        end else if (idx >= RVM_IDX_TIM0) begin
            off = RVM_OFF_TIM_CH0 - 9'({idx - RVM_IDX_TIM0, 2'b00});
        end
        return off;
    endfunction : rvm_vec_off

endpackage : rvm_pkg

// ===== bench/rvm_cpu_model.sv
`timescale 1ns/1ps
// cpu side: takes a vector after a random stall and logs it
module rvm_cpu_model
    import rvm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // vector port
    input wire logic irq_req,
    input wire logic [23:0] irq_vec,
    input wire logic ack_en,
    output logic vec_ack
);
    logic [23:0] taken[$];
    int unsigned stall;
    // selection moves two edges after a take, so rest before the next look
    initial begin
        vec_ack = 1'b0;
        forever begin
            @(posedge clk);
            if (!srst && ack_en && irq_req === 1'b1) begin
                stall = $urandom_range(3, 0);
                repeat (stall) @(posedge clk);
                vec_ack <= 1'b1;
                @(posedge clk);
                taken.push_back(irq_vec);
                vec_ack <= 1'b0;
                repeat (3) @(posedge clk);
            end
        end
    end
endmodule : rvm_cpu_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
    import rvm_pkg::*;
    logic clk, srst, wb_ack, sec_prog, reset_req, irq_req, wake_wait, wake_stop, vec_ack;
    logic por, low_voltage_reset, ext_n, nonmaskable_ext_request_n, cmf, wdt, e_done, e_ok, i_m, x_m, ack_en;
    logic [31:0] wb_rdata, rd;
    logic [1:0] sec_prog_value;
    logic [23:0] reset_vec, irq_vec, vbr;
    logic [3:0] trp;
    logic [31:0] fl;
    rvm_wb_req_t wbq;
    rvm_periph_evt_t evt;
    rvm_cpu_t cpu;
    int mismatches, compares, progs, j, n;
    assign cpu = {trp, vec_ack, i_m, x_m};
    rvm_vector_map u_rvm_vector_map (.clk(clk), .srst(srst), .wb_req(wbq), .wb_ack(wb_ack),
        .wb_rdata(wb_rdata), .por_pin(por), .lvr_pin(low_voltage_reset), .ext_reset_n_pin(ext_n),
        .nonmaskable_ext_request_n_pin(nonmaskable_ext_request_n), .clk_mon_fail(cmf), .wdog_timeout(wdt), .sec_bits(2'h1),
        .erase_done(e_done), .erase_ok(e_ok), .sec_prog(sec_prog),
        .sec_prog_value(sec_prog_value), .evt(evt), .cpu(cpu), .reset_req(reset_req),
        .reset_vec(reset_vec), .irq_req(irq_req), .irq_vec(irq_vec),
        .wake_wait(wake_wait), .wake_stop(wake_stop));
    rvm_cpu_model u_rvm_cpu_model (.clk(clk), .srst(srst), .irq_req(irq_req),
        .irq_vec(irq_vec), .ack_en(ack_en), .vec_ack(vec_ack));
    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // one-cycle program pulses are counted where they stand
    always @(posedge clk) begin
        if (sec_prog === 1'b1) progs++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // classic single cycle, waits on ack with a bound
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int k;
        k = 0;
        wbq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        if (k >= 50) mismatches++;
        rd = wb_rdata;
        wbq <= '0;
        @(posedge clk);
    endtask : bus
    // bounded wait on reset_req (s 0) or irq_req (s 1)
    task automatic till(input int s, input logic lvl);
        for (int k = 0; k < 12; k++) begin
            if ((s == 0 ? reset_req : irq_req) === lvl) break;
            @(posedge clk);
        end
    endtask : till
    function automatic logic [31:0] vexp(input logic [8:0] off);
        return {8'h00, vbr + 24'(off)};
    endfunction : vexp
    // event bit of source k: channels, then overflow, accumulator overflow, edge
    function automatic logic [10:0] ebit(input int k);
        return (k < 8) ? 11'h001 << (3 + k) : 11'h001 << (10 - k);
    endfunction : ebit
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // watchdog, run needs a few hundred cycles
    initial begin
        #500000;
        mismatches++;
        conclude();
    end
    initial begin
        {srst, ext_n, nonmaskable_ext_request_n, x_m} = 4'hf;
        {por, low_voltage_reset, cmf, wdt, e_done, e_ok, i_m, ack_en} = 8'h00;
        {wbq, evt, trp} = '0;
        {mismatches, compares, progs} = 0;
        j = $urandom(16);
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check(32'(reset_vec), 32'(RVM_RESET_VEC));
        bus(1'b0, RVM_REG_VBR, 32'h0);
        check(rd, {8'h00, RVM_VBR_RST});
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, RVM_REG_RSTAT, 32'h0);
        check(32'(rd[8]), 32'h1);
        vbr = 24'($urandom());
        bus(1'b1, RVM_REG_VBR, {8'h00, vbr});
        // all four traps at once, masks set, cpu takes them in turn
        ack_en <= 1'b1;
        i_m <= 1'b1;
        trp <= 4'hf;
        @(posedge clk);
        trp <= 4'h0;
        for (n = 0; n < 200 && u_rvm_cpu_model.taken.size() < 4; n++) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            check({8'h00, u_rvm_cpu_model.taken[k]}, vexp(RVM_OFF_TRAP1 - 9'(4 * k)));
        end
        ack_en <= 1'b0;
        bus(1'b1, RVM_REG_TIE, 32'hff);
        bus(1'b1, RVM_REG_TSC2, 32'h80);
        bus(1'b1, RVM_REG_PACTL, 32'h3);
        // each maskable source against a random lower one, the last source alone
        for (int k = 0; k < 11; k++) begin
            j = (k < 10) ? $urandom_range(10, k + 1) : k;
            fl = (32'h1 << k) | (32'h1 << j);
            i_m <= 1'b1;
            evt <= ebit(k) | ebit(j);
            @(posedge clk);
            evt <= '0;
            repeat (3) @(posedge clk);
            check(32'(irq_req), 32'h0);
            bus(1'b0, RVM_REG_FLAGS, 32'h0);
            check(rd, fl);
            i_m <= 1'b0;
            repeat (3) @(posedge clk);
            check(32'(irq_vec), vexp(RVM_OFF_TIM_CH0 - 9'(4 * k)));
            check(32'({irq_req, wake_wait, wake_stop}), 32'h6);
            bus(1'b1, RVM_REG_FLAGS, fl);
            repeat (2) @(posedge clk);
            check(32'(irq_req), 32'h0);
        end
        // nonmaskable pin: I does not block, X does
        i_m <= 1'b1;
        x_m <= 1'b0;
        nonmaskable_ext_request_n <= 1'b0;
        @(posedge clk);
        till(1, 1'b1);
        check(32'(irq_vec), vexp(RVM_OFF_NONMASKABLE_EXT_REQUEST));
        check(32'(wake_stop), 32'h1);
        x_m <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'({irq_req, wake_stop}), 32'h0);
        nonmaskable_ext_request_n <= 1'b1;
        // watchdog needs a nonzero rate, clock monitor the oscillator bit
        bus(1'b1, RVM_REG_WDOG, 32'h0);
        wdt <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'(reset_req), 32'h0);
        bus(1'b1, RVM_REG_WDOG, 32'($urandom_range(7, 1)));
        till(0, 1'b1);
        check(32'(reset_req), 32'h1);
        wdt <= 1'b0;
        till(0, 1'b0);
        bus(1'b1, RVM_REG_OSC, 32'h0);
        cmf <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'(reset_req), 32'h0);
        bus(1'b1, RVM_REG_OSC, 32'h80);
        till(0, 1'b1);
        check(32'(reset_req), 32'h1);
        cmf <= 1'b0;
        till(0, 1'b0);
        for (int p = 0; p < 3; p++) begin
            por <= (p == 0);
            low_voltage_reset <= (p == 1);
            ext_n <= (p != 2);
            @(posedge clk);
            till(0, 1'b1);
            check({7'h0, reset_req, reset_vec}, {8'h01, RVM_RESET_VEC});
            {por, low_voltage_reset, ext_n} <= 3'h1;
            till(0, 1'b0);
        end
        bus(1'b0, RVM_REG_RSTAT, 32'h0);
        check(32'(rd[4:0]), 32'h1f);
        // failed erase leaves security alone, good one reprograms it
        e_done <= 1'b1;
        @(posedge clk);
        e_done <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(progs), 32'h0);
        {e_done, e_ok} <= 2'h3;
        @(posedge clk);
        {e_done, e_ok} <= 2'h0;
        repeat (3) @(posedge clk);
        check(32'(progs), 32'h1);
        check(32'(sec_prog_value), 32'(RVM_SEC_UNSECURED));
        bus(1'b0, RVM_REG_RSTAT, 32'h0);
        check(32'(rd[8]), 32'h0);
        conclude();
    end
endmodule : tb
